// ---- src/dfps_regs.svh ----
// Constants of the drive fault protection supervisor: offsets, fields,
// reset values and timing counts.
// Assumes a 200 MHz system clock and byte addresses on a 32-bit APB.
`ifndef DFPS_REGS_SVH
`define DFPS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DFPS_OFF_CTRL 12'h000
`define DFPS_OFF_IVL 12'h004
`define DFPS_OFF_STATUS 12'h008
`define DFPS_OFF_IRQ_STS 12'h00C
`define DFPS_OFF_IRQ_EN 12'h010
`define DFPS_OFF_IRQ_CLR 12'h014
`define DFPS_OFF_CMD 12'h018
`define DFPS_OFF_HIST 12'h040
`define DFPS_OFF_HIST_END 12'h0A0

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define DFPS_CTRL_GAIN_LSB 0
`define DFPS_CTRL_LIMIT_LSB 8
`define DFPS_CTRL_GND_BIT 16
`define DFPS_CTRL_PLOSS_BIT 17
`define DFPS_CTRL_RELAY_BIT 18
`define DFPS_CTRL_RETRY_LSB 24
`define DFPS_GAIN_RST 7'h14
`define DFPS_GAIN_MAX 7'h64
`define DFPS_LIMIT_RST 8'h96
`define DFPS_LIMIT_MIN 8'h64
`define DFPS_LIMIT_MAX 8'hC8
`define DFPS_RETRY_RST 5'h00
`define DFPS_RETRY_MAX 5'h14
`define DFPS_IVL_RST 10'h00A
`define DFPS_IVL_MIN 10'h001
`define DFPS_IVL_MAX 10'h3E8

// ----------------------------------------------------------------------
// Interrupt bits and fault codes
// ----------------------------------------------------------------------
`define DFPS_IRQ_FAULT 0
`define DFPS_IRQ_RETRY 1
`define DFPS_IRQ_STALL 2
`define DFPS_IRQ_EXHAUST 3
`define DFPS_FC_GROUND 7'h0B
`define DFPS_FC_PHASE 7'h0C
`define DFPS_FC_MAX 7'h63

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DFPS_CLK_NS 5
`define DFPS_TICK_MS 100
`define DFPS_GND_CHK_MS 50
`define DFPS_TICK_CYCLES (`DFPS_TICK_MS * 1000000 / `DFPS_CLK_NS)
`define DFPS_GND_CYCLES (`DFPS_GND_CHK_MS * 1000000 / `DFPS_CLK_NS)

`endif

// ---- src/dfps_pkg.sv ----
// Types shared by the fault protection supervisor modules.
// Assumes dfps_regs.svh holds all numeric constants.
package dfps_pkg;

	// Supervisor states.
	typedef enum logic [1:0] {
		ST_GND_CHK,
		ST_RUN,
		ST_RETRY_WAIT,
		ST_FAULT_HOLD
	} dfps_state_type;

	// One fault history entry with its snapshot.
	typedef struct packed {
		logic [6:0] code;
		logic [15:0] freq;
		logic [15:0] current;
		logic [15:0] vbus;
		logic [9:0] din;
		logic [4:0] dout;
		logic [15:0] pon_time;
		logic [15:0] run_time;
	} dfps_entry_type;

endpackage : dfps_pkg

// ---- src/dfps_tick.sv ----
// Divider giving a one-cycle enable pulse every 0.1 s while running.
// Assumes one system clock; dropping run restarts the period.
`timescale 1ns/1ps
module dfps_tick #(
	parameter int TICK_CYCLES = 20000000
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} dfps_tick_type;

	dfps_tick_type r;
	dfps_tick_type n;

	// Count while running and pulse at the end of each period.
	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (!run) begin
			n.cnt = 32'h0000_0000;
		end else if (r.cnt >= 32'(TICK_CYCLES - 1)) begin
			n.cnt = 32'h0000_0000;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 32'h0000_0001;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick = r.tick;
endmodule : dfps_tick

// ---- src/dfps_stall.sv ----
// Current stall limiter: freezes the ramp and grades the suppression.
// Assumes current and limit both in percent of rated current.
`timescale 1ns/1ps
module dfps_stall (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ramping,
	input wire logic [15:0] current,
	input wire logic [7:0] limit,
	input wire logic [6:0] gain,
	output logic hold,
	output logic [7:0] suppress
);
	typedef struct packed {
		logic hold;
		logic [7:0] suppress;
	} dfps_stall_type;

	dfps_stall_type r;
	dfps_stall_type n;

	// Hold while ramping over the limit with nonzero gain; suppression grows with excess and gain.
	always_comb begin
		logic [15:0] excess;
		logic [22:0] prod;
		excess = 16'h0000;
		prod = 23'h00_0000;
		n = r;
		if (current > {8'h00, limit}) begin
			excess = current - {8'h00, limit};
		end
		prod = excess * gain;
		n.hold = ramping && (gain != 7'h00) && (excess != 16'h0000);
		n.suppress = (gain == 7'h00) ? 8'h00 :
			(prod > 23'h00_00FF) ? 8'hFF : prod[7:0];
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign hold = r.hold;
	assign suppress = r.suppress;
endmodule : dfps_stall

// ---- src/dfps_top.sv ----
// Drive fault protection supervisor: stall limit, ground check, phase
// loss, automatic fault reset and a three-entry fault history on APB.
// Assumes measurements and terminal states synchronous to clk_sys.
`timescale 1ns/1ps
`include "dfps_regs.svh"
module dfps_top #(
	parameter int TICK_CYCLES = `DFPS_TICK_CYCLES,
	parameter int GND_CYCLES = `DFPS_GND_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ramping,
	input wire logic running,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] out_current,
	input wire logic [15:0] bus_voltage,
	input wire logic [15:0] power_on_time,
	input wire logic [15:0] run_time,
	input wire logic [9:0] digital_input_terminal,
	input wire logic digital_output_two,
	input wire logic digital_output_one,
	input wire logic relay_output_two,
	input wire logic relay_output_one,
	input wire logic pulse_output_terminal,
	input wire logic ground_leak,
	input wire logic phase_missing,
	input wire logic ext_fault,
	input wire logic [6:0] ext_fault_code,
	output logic ramp_hold,
	output logic [7:0] stall_suppress,
	output logic motor_phase_outputs,
	output logic drive_trip,
	output logic fault_relay_output,
	output logic irq
);
	import dfps_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		dfps_state_type st;
		logic [6:0] gain;
		logic [7:0] limit;
		logic gnd_en;
		logic ploss_en;
		logic relay_sel;
		logic [4:0] retry_max;
		logic [4:0] retry_used;
		logic [9:0] ivl;
		logic [9:0] wait_cnt;
		logic [31:0] gnd_cnt;
		logic [3:0] irq_sts;
		logic [3:0] irq_en;
		logic hold_d;
		logic phase_on;
		logic trip;
		logic relay;
		dfps_entry_type [2:0] hist;
		logic [31:0] prdata;
		logic pslverr;
	} dfps_regs_type;

	dfps_regs_type r;
	dfps_regs_type n;
	logic tick;
	logic hold;

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------

	// Stall limiter works from the configured limit and gain.
	dfps_stall u_stall (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ramping(ramping),
		.current(out_current),
		.limit(r.limit),
		.gain(r.gain),
		.hold(hold),
		.suppress(stall_suppress)
	);

	// Interval ticks run only while an automatic reset is pending.
	dfps_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(r.st == ST_RETRY_WAIT),
		.tick(tick)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// Bus access, fault detection, history and state sequencing.
	always_comb begin
		logic setup;
		logic wr;
		logic fault;
		logic [6:0] code;
		logic [3:0] ev;
		logic [3:0] clr;
		logic [2:0] ent;
		logic [2:0] fld;
		dfps_entry_type e;
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		fault = 1'b0;
		code = 7'h00;
		ev = 4'h0;
		clr = 4'h0;
		ent = paddr[7:5] - 3'h2;
		fld = paddr[4:2];
		e = r.hist[0];
		n = r;

		// Register reads are prepared in the setup cycle.
		if (setup) begin
			n.prdata = 32'h0000_0000;
			n.pslverr = 1'b0;
			case (paddr)
				`DFPS_OFF_CTRL: begin
					n.prdata[`DFPS_CTRL_GAIN_LSB +: 7] = r.gain;
					n.prdata[`DFPS_CTRL_LIMIT_LSB +: 8] = r.limit;
					n.prdata[`DFPS_CTRL_GND_BIT] = r.gnd_en;
					n.prdata[`DFPS_CTRL_PLOSS_BIT] = r.ploss_en;
					n.prdata[`DFPS_CTRL_RELAY_BIT] = r.relay_sel;
					n.prdata[`DFPS_CTRL_RETRY_LSB +: 5] = r.retry_max;
				end
				`DFPS_OFF_IVL: begin
					n.prdata[9:0] = r.ivl;
				end
				`DFPS_OFF_STATUS: begin
					n.prdata[1:0] = r.st;
					n.prdata[2] = hold;
					n.prdata[3] = r.trip;
					n.prdata[4] = r.relay;
					n.prdata[12:8] = r.retry_used;
				end
				`DFPS_OFF_IRQ_STS: begin
					n.prdata[3:0] = r.irq_sts;
				end
				`DFPS_OFF_IRQ_EN: begin
					n.prdata[3:0] = r.irq_en;
				end
				`DFPS_OFF_IRQ_CLR, `DFPS_OFF_CMD: begin
					n.prdata = 32'h0000_0000;
				end
				default: begin
					if (paddr >= `DFPS_OFF_HIST && paddr < `DFPS_OFF_HIST_END
						&& paddr[1:0] == 2'b00) begin
						e = r.hist[ent[1:0]];
						case (fld)
							3'h0: n.prdata[6:0] = e.code;
							3'h1: n.prdata[15:0] = e.freq;
							3'h2: n.prdata[15:0] = e.current;
							3'h3: n.prdata[15:0] = e.vbus;
							3'h4: n.prdata[9:0] = e.din;
							3'h5: n.prdata[4:0] = e.dout;
							3'h6: n.prdata[15:0] = e.pon_time;
							default: n.prdata[15:0] = e.run_time;
						endcase
					end else begin
						n.pslverr = 1'b1;
					end
				end
			endcase
		end

		// Register writes take effect at the access edge, clamped to range.
		if (wr) begin
			case (paddr)
				`DFPS_OFF_CTRL: begin
					n.gain = pwdata[`DFPS_CTRL_GAIN_LSB +: 7];
					if (n.gain > `DFPS_GAIN_MAX) begin
						n.gain = `DFPS_GAIN_MAX;
					end
					n.limit = pwdata[`DFPS_CTRL_LIMIT_LSB +: 8];
					if (n.limit < `DFPS_LIMIT_MIN) begin
						n.limit = `DFPS_LIMIT_MIN;
					end else if (n.limit > `DFPS_LIMIT_MAX) begin
						n.limit = `DFPS_LIMIT_MAX;
					end
					n.gnd_en = pwdata[`DFPS_CTRL_GND_BIT];
					n.ploss_en = pwdata[`DFPS_CTRL_PLOSS_BIT];
					n.relay_sel = pwdata[`DFPS_CTRL_RELAY_BIT];
					n.retry_max = pwdata[`DFPS_CTRL_RETRY_LSB +: 5];
					if (n.retry_max > `DFPS_RETRY_MAX) begin
						n.retry_max = `DFPS_RETRY_MAX;
					end
				end
				`DFPS_OFF_IVL: begin
					n.ivl = pwdata[9:0];
					if (n.ivl < `DFPS_IVL_MIN) begin
						n.ivl = `DFPS_IVL_MIN;
					end else if (n.ivl > `DFPS_IVL_MAX) begin
						n.ivl = `DFPS_IVL_MAX;
					end
				end
				`DFPS_OFF_IRQ_EN: begin
					n.irq_en = pwdata[3:0];
				end
				`DFPS_OFF_IRQ_CLR: begin
					clr = pwdata[3:0];
				end
				`DFPS_OFF_CMD: begin
					// A manual reset leaves any fault state and refills retries.
					if (pwdata[0] && (r.st == ST_RETRY_WAIT
						|| r.st == ST_FAULT_HOLD)) begin
						n.st = ST_RUN;
						n.retry_used = 5'h00;
					end
				end
				default: begin
				end
			endcase
		end

		// Fault sources, ground and phase checks first.
		case (r.st)
			ST_GND_CHK: begin
				if (ground_leak) begin
					fault = 1'b1;
					code = `DFPS_FC_GROUND;
				end
			end
			ST_RUN: begin
				if (r.ploss_en && running && phase_missing) begin
					fault = 1'b1;
					code = `DFPS_FC_PHASE;
				end else if (ext_fault) begin
					fault = 1'b1;
					code = (ext_fault_code > `DFPS_FC_MAX) ? `DFPS_FC_MAX :
						ext_fault_code;
				end
			end
			default: begin
			end
		endcase
		if (code == 7'h00) begin
			fault = 1'b0;
		end

		// Sequencing of power-up check, run and fault states.
		case (r.st)
			ST_GND_CHK: begin
				n.gnd_cnt = r.gnd_cnt + 32'h0000_0001;
				if (!r.gnd_en || r.gnd_cnt >= 32'(GND_CYCLES - 1)) begin
					n.st = ST_RUN;
				end
			end
			ST_RETRY_WAIT: begin
				if (tick) begin
					n.wait_cnt = r.wait_cnt + 10'h001;
					if (n.wait_cnt >= r.ivl) begin
						n.st = ST_RUN;
						n.retry_used = r.retry_used + 5'h01;
						ev[`DFPS_IRQ_RETRY] = 1'b1;
					end
				end
			end
			default: begin
			end
		endcase

		// A new fault shifts history and snapshots the latest entry.
		if (fault) begin
			n.hist[0] = r.hist[1];
			n.hist[1] = r.hist[2];
			n.hist[2].code = code;
			n.hist[2].freq = out_freq;
			n.hist[2].current = out_current;
			n.hist[2].vbus = bus_voltage;
			n.hist[2].din = digital_input_terminal;
			n.hist[2].dout = {digital_output_two, digital_output_one,
				relay_output_two, relay_output_one,
				pulse_output_terminal};
			n.hist[2].pon_time = power_on_time;
			n.hist[2].run_time = run_time;
			n.wait_cnt = 10'h000;
			ev[`DFPS_IRQ_FAULT] = 1'b1;
			if (r.retry_used < r.retry_max) begin
				n.st = ST_RETRY_WAIT;
			end else begin
				n.st = ST_FAULT_HOLD;
				ev[`DFPS_IRQ_EXHAUST] = 1'b1;
			end
		end

		// Stall entry event from the limiter's hold edge.
		n.hold_d = hold;
		ev[`DFPS_IRQ_STALL] = hold && !r.hold_d;

		// Sticky status: a new event wins over a same-cycle clear.
		n.irq_sts = (r.irq_sts & ~clr) | ev;

		// Terminal outputs follow the next state.
		n.phase_on = (n.st == ST_GND_CHK) && r.gnd_en;
		n.trip = (n.st == ST_RETRY_WAIT) || (n.st == ST_FAULT_HOLD);
		n.relay = (n.st == ST_FAULT_HOLD)
			|| (n.st == ST_RETRY_WAIT && r.relay_sel);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------

	// State register with documented defaults after reset.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.st <= ST_GND_CHK;
			r.gain <= `DFPS_GAIN_RST;
			r.limit <= `DFPS_LIMIT_RST;
			r.gnd_en <= 1'b1;
			r.ploss_en <= 1'b1;
			r.relay_sel <= 1'b0;
			r.retry_max <= `DFPS_RETRY_RST;
			r.ivl <= `DFPS_IVL_RST;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// APB answers in the first access cycle.
	assign pready = 1'b1;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr && psel && penable;

	// Terminal and interrupt outputs.
	assign ramp_hold = hold;
	assign motor_phase_outputs = r.phase_on;
	assign drive_trip = r.trip;
	assign fault_relay_output = r.relay;
	assign irq = |(r.irq_sts & r.irq_en);
endmodule : dfps_top

// ---- sim/dfps_top_props.sv ----
// Port checker for the fault protection supervisor top level.
// Assumes it is bound to dfps_top and sees only its ports.
`timescale 1ns/1ps
module dfps_top_props #(
	parameter int GND_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic ramping,
	input wire logic [15:0] out_current,
	input wire logic ext_fault,
	input wire logic phase_missing,
	input wire logic ground_leak,
	input wire logic pslverr,
	input wire logic ramp_hold,
	input wire logic [7:0] stall_suppress,
	input wire logic motor_phase_outputs,
	input wire logic drive_trip,
	input wire logic fault_relay_output
);
	int unsigned cyc;
	int unsigned gnd_len;
	// Edges since reset and length of the present phase drive.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cyc <= 0;
			gnd_len <= 0;
		end else begin
			cyc <= cyc + 1;
			gnd_len <= motor_phase_outputs ? gnd_len + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	hold_cause_a: assert property ($rose(ramp_hold) |->
		$past(ramping) && $past(out_current) > 16'h0064)
		else $error("ramp hold rose without ramp and overcurrent");
	hold_stop_a: assert property (!ramping |=> !ramp_hold)
		else $error("ramp hold outside ramping");
	hold_end_a: assert property ($fell(ramp_hold) |->
		$past(!ramping) || $past(out_current) <= 16'h00C8)
		else $error("ramp hold dropped while overcurrent");
	supp_zero_a: assert property (out_current <= 16'h0064 |=>
		stall_suppress == 8'h00)
		else $error("suppression below the lowest limit");
	relay_trip_a: assert property (fault_relay_output |-> drive_trip)
		else $error("fault relay active without trip");
	phase_notrip_a: assert property (motor_phase_outputs |-> !drive_trip)
		else $error("phases driven while tripped");
	phase_start_a: assert property ($rose(motor_phase_outputs) |-> cyc <= 2)
		else $error("phase drive not at power-up");
	phase_len_a: assert property (gnd_len <= GND_CYCLES)
		else $error("ground check drive too long");
	trip_cause_a: assert property ($rose(drive_trip) |->
		$past(ext_fault || phase_missing || ground_leak) ||
		$past(ext_fault || phase_missing || ground_leak, 2))
		else $error("trip without a fault source");
	slverr_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
endmodule : dfps_top_props

bind dfps_top dfps_top_props #(
	.GND_CYCLES(GND_CYCLES)
) u_props (
	.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
	.ramping(ramping), .out_current(out_current), .ext_fault(ext_fault),
	.phase_missing(phase_missing), .ground_leak(ground_leak),
	.pslverr(pslverr), .ramp_hold(ramp_hold),
	.stall_suppress(stall_suppress),
	.motor_phase_outputs(motor_phase_outputs), .drive_trip(drive_trip),
	.fault_relay_output(fault_relay_output)
);

// ---- sim/dfps_plant.sv ----
// Model of the motor power stage and its current measurement.
// Assumes the bench commands load, ground short and open phase.
`timescale 1ns/1ps
module dfps_plant #(
	parameter logic [15:0] VBUS = 16'h0136
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ramping,
	input wire logic ramp_hold,
	input wire logic drive_trip,
	input wire logic motor_phase_outputs,
	input wire logic [15:0] load,
	input wire logic short_cmd,
	input wire logic open_cmd,
	output logic [15:0] out_freq,
	output logic [15:0] out_current,
	output logic [15:0] bus_voltage,
	output logic running,
	output logic ground_leak,
	output logic phase_missing
);
	// Frequency ramps unless held by the stall limiter or tripped.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			out_freq <= 16'h0000;
		end else if (ramping && !ramp_hold && !drive_trip) begin
			out_freq <= out_freq + 16'h0001;
		end
	end
	// A tripped stage carries no current; leakage needs driven phases.
	assign out_current = drive_trip ? 16'h0000 : load;
	assign bus_voltage = VBUS;
	assign running = !drive_trip;
	assign ground_leak = motor_phase_outputs && short_cmd;
	assign phase_missing = running && open_cmd;
endmodule : dfps_plant

// ---- sim/testbench.sv ----
// Self-checking bench for the fault protection supervisor.
// Assumes the plant model and bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
	import dfps_pkg::*;
	localparam logic [15:0] VB = 16'h0136;
	logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, ramp_hold, mpo, trip, relay, irq, err;
	logic ramping = 0, ext_fault = 0, short_cmd = 0, open_cmd = 0;
	logic [6:0] ext_code = 7'h00;
	logic [15:0] load = 16'h0000, pon = 16'h1234, runt = 16'h0567;
	logic [15:0] out_freq, out_current, bus_voltage, ex [3][8];
	logic running, ground_leak, phase_missing;
	logic [9:0] din = 10'h201;
	logic [4:0] dout = 5'h12;
	logic [7:0] supp;
	int errors = 0, n_tests = 0, n, p;
	logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
		12'h018, 12'h080, 12'h020};
	logic [31:0] rx [8] = '{32'h0003_9614, 32'h0000_000A, 32'h0000_0001,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000};
	logic [6:0] sg [4] = '{7'h00, 7'h14, 7'h05, 7'h64};
	logic [15:0] sc [4] = '{16'h0096, 16'h0078, 16'h0069, 16'h0064};

	// 200 MHz system clock.
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	dfps_top #(.TICK_CYCLES(10), .GND_CYCLES(20)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ramping(ramping),
		.running(running), .out_freq(out_freq), .out_current(out_current),
		.bus_voltage(bus_voltage), .power_on_time(pon), .run_time(runt),
		.digital_input_terminal(din), .digital_output_two(dout[4]),
		.digital_output_one(dout[3]), .relay_output_two(dout[2]),
		.relay_output_one(dout[1]), .pulse_output_terminal(dout[0]),
		.ground_leak(ground_leak), .phase_missing(phase_missing),
		.ext_fault(ext_fault), .ext_fault_code(ext_code),
		.ramp_hold(ramp_hold), .stall_suppress(supp),
		.motor_phase_outputs(mpo), .drive_trip(trip),
		.fault_relay_output(relay), .irq(irq));

	dfps_plant #(.VBUS(VB)) u_plant (
		.clk_sys(clk_sys), .rst_b(rst_b), .ramping(ramping),
		.ramp_hold(ramp_hold), .drive_trip(trip), .motor_phase_outputs(mpo),
		.load(load), .short_cmd(short_cmd), .open_cmd(open_cmd),
		.out_freq(out_freq), .out_current(out_current),
		.bus_voltage(bus_voltage), .running(running),
		.ground_leak(ground_leak), .phase_missing(phase_missing));

	task automatic close_out();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			errors++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	// Counts edges until the trip output reaches the given level.
	task automatic wait_for(input logic v, output int c);
		for (c = 0; c < 200; c++) begin
			@(posedge clk_sys);
			if (trip === v) return;
		end
		errors++;
		close_out();
	endtask : wait_for

	// Sets new snapshot inputs and records the entry they should give.
	task automatic prep(input int i, input logic [6:0] c,
		input logic [9:0] d, input logic [4:0] o, input logic [15:0] l);
		din <= d;
		dout <= o;
		load <= l;
		pon <= pon + 16'h0100;
		runt <= runt + 16'h0011;
		@(posedge clk_sys);
		ex[i] = '{{9'h000, c}, out_freq, l, VB, {6'h00, d}, {11'h000, o},
			pon, runt};
	endtask : prep

	task automatic fault(input logic [6:0] c);
		ext_fault <= 1;
		ext_code <= c;
		@(posedge clk_sys);
		ext_fault <= 0;
	endtask : fault

	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1;
		n = 0;
		repeat (40) begin
			@(posedge clk_sys);
			n += mpo;
		end
		// The check leaves on its last count, so drive spans one edge less.
		chk(n, 19);
		// Reset values and the unmapped address, one row each.
		for (int r = 0; r < 8; r++) begin
			apb(0, ra[r], 32'h0000_0000);
			chk({rd[30:0], err}, {rx[r][30:0], r == 7});
		end
		// Stall limit at 100 percent for several gains and currents.
		for (int s = 0; s < 4; s++) begin
			apb(1, 12'h000, {8'h00, 8'h03, 8'h64, 1'b0, sg[s]});
			load <= sc[s];
			ramping <= 1;
			repeat (3) @(posedge clk_sys);
			p = (sc[s] > 100) ? (sc[s] - 100) * sg[s] : 0;
			chk(ramp_hold, sg[s] != 0 && sc[s] > 100);
			chk(supp, p > 255 ? 255 : p);
		end
		ramping <= 0;
		repeat (3) @(posedge clk_sys);
		chk(ramp_hold, 0);
		apb(1, 12'h000, 32'h0201_9614);
		apb(1, 12'h004, 32'h0000_0002);
		open_cmd <= 1;
		repeat (5) @(posedge clk_sys);
		chk(trip, 0);
		open_cmd <= 0;
		chk(irq, 0);
		apb(1, 12'h010, 32'h0000_000F);
		// The enable lands at the access edge; look once it has settled.
		@(posedge clk_sys);
		chk(irq, 1);
		prep(0, 7'h05, 10'h201, 5'h12, 16'h0050);
		fault(7'h05);
		wait_for(1, n);
		chk(relay, 0);
		wait_for(0, n);
		chk(n >= 8 && n <= 24, 1);
		apb(1, 12'h000, 32'h0207_9614);
		prep(1, 7'h0C, 10'h0F0, 5'h0D, 16'h0040);
		open_cmd <= 1;
		wait_for(1, n);
		open_cmd <= 0;
		chk(relay, 1);
		wait_for(0, n);
		prep(2, 7'h63, 10'h3FF, 5'h01, 16'h0070);
		fault(7'h78);
		wait_for(1, n);
		repeat (40) @(posedge clk_sys);
		chk({trip, relay}, 2'b11);
		for (int e = 0; e < 3; e++) begin
			for (int f = 0; f < 8; f++) begin
				apb(0, 12'h040 + 12'(e * 32 + f * 4), 32'h0000_0000);
				chk(rd, ex[e][f]);
			end
		end
		apb(0, 12'h00C, 32'h0000_0000);
		chk(rd, 32'h0000_000F);
		apb(1, 12'h014, 32'h0000_000F);
		apb(0, 12'h00C, 32'h0000_0000);
		chk({rd[3:0], irq}, 5'h00);
		apb(1, 12'h018, 32'h0000_0001);
		wait_for(0, n);
		// Second reset with the motor shorted to ground.
		short_cmd <= 1;
		rst_b <= 0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1;
		wait_for(1, n);
		chk(mpo, 0);
		apb(0, 12'h080, 32'h0000_0000);
		chk(rd, 32'h0000_000B);
		close_out();
	end
endmodule : testbench
